// ---- inc/csg_defs.svh ----
// Operation
// (R1) Halt drains, freezes pipeline, raises sleep indicator
// (R2) Top gating: gate clock except wake logic
// (R3) Interrupts, nmi, reset, debug watched asleep
// (R4) Enabled interrupt, nmi, debug wake with state kept
// (R5) Reset ends sleep and clears state
// (R6) Reduced-power bit drives reduced-power request output
// (R7) Reduced-power request never gates own clock
// (R8) External logic keeps sleep 100 cycles minimum
// (R9) Without top gating external logic stops clock
// (R10) Without top gating only reset restarts
// (R11) Without top gating external logic detects wake
// (R12) Fine gating clocks only accessed register block
// (R13) Shared write enable still reaches idle blocks
// (R14) External supply restored before wake interrupt
// (R15) Indicators drop on wake, reset, bit clear
`ifndef CSG_DEFS_SVH
`define CSG_DEFS_SVH
`define CSG_ADDR_CTRL       4'h0
`define CSG_ADDR_STATUS     4'h4
`define CSG_ADDR_BLKEN      4'h8
`define CSG_ADDR_WAKECNT    4'hc
`define CSG_CTRL_RP_BIT     0
`define CSG_CTRL_HALT_BIT   1
`define CSG_CTRL_IE_LSB     8
`define CSG_CTRL_RESET      32'h0000_0000
`define CSG_BLKEN_RESET     4'hf
`define CSG_NUM_BLOCKS      4
`define CSG_NUM_INT         6
`define CSG_DRAIN_CYCLES    4'h3
`define CSG_WAKE_CYCLES     4'h2
`define CSG_MIN_SLEEP_CYC   100
`define CSG_RESP_OKAY       2'b00
`define CSG_RESP_SLVERR     2'b10
`endif

// ---- inc/csg_pkg.sv ----
package csg_pkg;
   typedef enum logic [2:0] {
      CSG_RUN   = 3'b000,
      CSG_DRAIN = 3'b001,
      CSG_FREEZE= 3'b010,
      CSG_SLEEP = 3'b011,
      CSG_WAKE  = 3'b100
   } csg_state_t;
endpackage : csg_pkg

// ---- hdl/csg_sync.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs; the first stage feeds only the second.
module csg_sync #(parameter int W = 1) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : csg_sync

// ---- hdl/csg_clk_gate.sv ----
`timescale 1ns/1ps
// Latch-based glitch-free clock gate; enable is caught while the clock is low.
module csg_clk_gate (
   input  wire logic clk_in,
   input  wire logic enable,
   output logic      clk_out
);
   logic en_latch;
   always_latch begin
      if (!clk_in) begin
         en_latch <= enable;
      end
   end
   assign clk_out = clk_in & en_latch;
endmodule : csg_clk_gate

// ---- hdl/csg_core_sleep.sv ----
`timescale 1ns/1ps
`include "csg_defs.svh"
module csg_core_sleep #(
   parameter bit TOP_GATING  = 1'b1,
   parameter bit FINE_GATING = 1'b1
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // AXI4-Lite slave
   input  wire logic [3:0]                    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [3:0]                    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // Core side
   input  wire logic                          halt_exec,
   input  wire logic                          ops_pending,
   input  wire logic [`CSG_NUM_INT-1:0]       core_int,
   input  wire logic                          core_nmi,
   input  wire logic                          debug_mode_signal,
   input  wire logic                          regblk_we,
   input  wire logic [`CSG_NUM_BLOCKS-1:0]    regblk_sel,
   output logic                               sleep_indicator,
   output logic                               reduced_power_request,
   output logic                               pipeline_freeze,
   output logic                               core_clk,
   output logic                               wake_clk,
   output logic [`CSG_NUM_BLOCKS-1:0]         regblk_clk,
   output logic [`CSG_NUM_BLOCKS-1:0]         regblk_we_out
);
   // Pins from outside the clock domain pass two flops first
   logic [`CSG_NUM_INT+1:0] pins_sync;
   csg_sync #(.W(`CSG_NUM_INT + 2)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({debug_mode_signal, core_nmi, core_int}),
      .q       (pins_sync)
   ); // see (R3)

   wire [`CSG_NUM_INT-1:0] int_s  = pins_sync[`CSG_NUM_INT-1:0];
   wire                    nmi_s  = pins_sync[`CSG_NUM_INT];
   wire                    dbg_s  = pins_sync[`CSG_NUM_INT+1];

   // Control register: reduced-power bit, software halt, interrupt enables
   logic [31:0]                   ctrl;
   logic [`CSG_NUM_BLOCKS-1:0]    blk_en;
   logic [15:0]                   wake_count;
   csg_pkg::csg_state_t           state;
   csg_pkg::csg_state_t           next_state;
   logic [3:0]                    cnt;
   logic [3:0]                    next_cnt;
   logic                          wake_seen;

   wire                    rp_bit    = ctrl[`CSG_CTRL_RP_BIT];
   wire                    sw_halt   = ctrl[`CSG_CTRL_HALT_BIT];
   wire [`CSG_NUM_INT-1:0] int_en    = ctrl[`CSG_CTRL_IE_LSB +: `CSG_NUM_INT];

   // Any enabled interrupt, nmi or debug request wakes the core
   wire wake_event = (|(int_s & int_en)) | nmi_s | dbg_s; // see (R4)
   wire halt_req   = halt_exec | sw_halt;

   // AXI4-Lite write path: address and data accepted in either order
   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   wire aw_fire  = s_axi_awvalid && s_axi_awready;
   wire w_fire   = s_axi_wvalid && s_axi_wready;
   wire have_aw  = aw_held | aw_fire;
   wire have_w   = w_held | w_fire;
   wire wr_go    = have_aw && have_w && !s_axi_bvalid;
   wire [3:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;

   function automatic logic [31:0] csg_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : csg_merge

   function automatic logic csg_mapped(input logic [3:0] a);
      return (a == `CSG_ADDR_CTRL) || (a == `CSG_ADDR_STATUS) ||
             (a == `CSG_ADDR_BLKEN) || (a == `CSG_ADDR_WAKECNT);
   endfunction : csg_mapped

   wire wr_ctrl  = wr_go && (wr_addr == `CSG_ADDR_CTRL);
   wire wr_blken = wr_go && (wr_addr == `CSG_ADDR_BLKEN);
   wire wr_ok    = csg_mapped(wr_addr) && (wr_addr != `CSG_ADDR_STATUS)
                   && (wr_addr != `CSG_ADDR_WAKECNT);
   wire [31:0] ctrl_new  = csg_merge(ctrl, wr_data, wr_strb);
   wire [31:0] blken_new = csg_merge({28'h0, blk_en}, wr_data, wr_strb);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 4'h0;
         w_data       <= 32'h0;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CSG_RESP_OKAY;
      end else begin
         if (aw_fire && !wr_go) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (w_fire && !wr_go) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `CSG_RESP_OKAY : `CSG_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Registers; reset clears ctrl, including a pending sleep, and sets every block enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl   <= `CSG_CTRL_RESET;   // see (R5)
         blk_en <= `CSG_BLKEN_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl <= ctrl_new;          // see (R6) (R15)
         end else if (state == csg_pkg::CSG_SLEEP && sw_halt) begin
            // Software halt is one-shot: consumed on sleep entry
            ctrl[`CSG_CTRL_HALT_BIT] <= 1'b0;
         end
         if (wr_blken) begin
            blk_en <= blken_new[`CSG_NUM_BLOCKS-1:0];
         end
      end
   end

   // AXI4-Lite read path, one cycle latency
   assign s_axi_arready = !s_axi_rvalid;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire [31:0] status_word = {24'h0, wake_seen, reduced_power_request,
                              sleep_indicator, pipeline_freeze, 1'b0, state};
   wire [31:0] rd_mux =
      (s_axi_araddr == `CSG_ADDR_CTRL)    ? ctrl :
      (s_axi_araddr == `CSG_ADDR_STATUS)  ? status_word :
      (s_axi_araddr == `CSG_ADDR_BLKEN)   ? {28'h0, blk_en} :
      (s_axi_araddr == `CSG_ADDR_WAKECNT) ? {16'h0, wake_count} : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `CSG_RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= csg_mapped(s_axi_araddr) ? `CSG_RESP_OKAY : `CSG_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Sleep sequencer: drain outstanding work, freeze, then sleep
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      unique case (state)
         csg_pkg::CSG_RUN: begin
            if (halt_req) begin
               next_state = csg_pkg::CSG_DRAIN;
               next_cnt   = `CSG_DRAIN_CYCLES;
            end
         end
         csg_pkg::CSG_DRAIN: begin
            // Outstanding operations must finish before the freeze
            if (!ops_pending) begin
               if (cnt == 4'h0) begin
                  next_state = csg_pkg::CSG_FREEZE;
               end else begin
                  next_cnt = cnt - 4'h1;
               end
            end // see (R1)
         end
         csg_pkg::CSG_FREEZE: begin
            next_state = csg_pkg::CSG_SLEEP; // see (R1)
         end
         csg_pkg::CSG_SLEEP: begin
            // Without top gating this domain may lose its clock here;
            // only reset brings it back then
            if (wake_event) begin
               next_state = csg_pkg::CSG_WAKE;
               next_cnt   = `CSG_WAKE_CYCLES;
            end // see (R4) (R10)
         end
         csg_pkg::CSG_WAKE: begin
            if (cnt == 4'h0) begin
               next_state = csg_pkg::CSG_RUN;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         default: begin
            next_state = csg_pkg::CSG_RUN;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state      <= csg_pkg::CSG_RUN; // see (R5)
         cnt        <= 4'h0;
         wake_seen  <= 1'b0;
         wake_count <= 16'h0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         if (state == csg_pkg::CSG_SLEEP && wake_event) begin
            wake_seen  <= 1'b1;
            wake_count <= wake_count + 16'h1;
         end else if (wr_ctrl) begin
            wake_seen <= 1'b0;
         end
      end
   end

   // Indicator and request outputs come from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_indicator       <= 1'b0;
         reduced_power_request <= 1'b0;
         pipeline_freeze       <= 1'b0;
      end else begin
         sleep_indicator       <= (next_state == csg_pkg::CSG_SLEEP); // see (R1) (R15)
         reduced_power_request <= wr_ctrl ? ctrl_new[`CSG_CTRL_RP_BIT] : rp_bit; // see (R6)
         pipeline_freeze       <= (next_state == csg_pkg::CSG_FREEZE) ||
                                  (next_state == csg_pkg::CSG_SLEEP) ||
                                  (next_state == csg_pkg::CSG_WAKE);
      end
   end

   // Core clock gated only by sleep under top gating, never by the
   // reduced-power request; wake logic keeps the free-running clock
   wire core_clk_en = !(TOP_GATING && sleep_indicator); // see (R2) (R7)
   csg_clk_gate u_core_gate (
      .clk_in  (aclk),
      .enable  (core_clk_en),
      .clk_out (core_clk)
   ); // see (R2)
   assign wake_clk = aclk; // see (R2) (R3)

   // Fine grain: each register block gets a clock edge only on its access
   genvar g;
   generate
      for (g = 0; g < `CSG_NUM_BLOCKS; g++) begin : g_blk
         wire blk_clk_en = core_clk_en &&
                           (FINE_GATING ? (regblk_we && regblk_sel[g] && blk_en[g]) : 1'b1);
         csg_clk_gate u_blk_gate (
            .clk_in  (aclk),
            .enable  (blk_clk_en),
            .clk_out (regblk_clk[g])
         ); // see (R12)
         assign regblk_we_out[g] = regblk_we; // see (R13)
      end
   endgenerate
endmodule : csg_core_sleep

// ---- dv/csg_sleep_chk.sv ----
`timescale 1ns/1ps
`include "csg_defs.svh"
module csg_sleep_chk #(
   parameter bit TOP_GATING  = 1'b1,
   parameter bit FINE_GATING = 1'b1
) (
   input wire logic                       aclk,
   input wire logic                       aresetn,
   input wire logic                       ops_pending,
   input wire logic                       core_nmi,
   input wire logic                       regblk_we,
   input wire logic [`CSG_NUM_BLOCKS-1:0] regblk_sel,
   input wire logic                       sleep_indicator,
   input wire logic                       reduced_power_request,
   input wire logic                       pipeline_freeze,
   input wire logic                       core_clk,
   input wire logic                       wake_clk,
   input wire logic [`CSG_NUM_BLOCKS-1:0] regblk_clk,
   input wire logic [`CSG_NUM_BLOCKS-1:0] regblk_we_out
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_sleep_frozen: assert property (sleep_indicator |-> pipeline_freeze)
      else $error("sleep indicator without frozen pipeline");
   // Freeze only follows a drain cycle in which nothing was outstanding
   a_sleep_drained: assert property ($rose(pipeline_freeze) |-> !$past(ops_pending))
      else $error("pipeline frozen with operations pending");
   a_nmi_wakes: assert property (
      $rose(core_nmi) && sleep_indicator |-> ##[1:8] !sleep_indicator)
      else $error("nmi did not wake the core");
   a_reset_clears: assert property (disable iff (1'b0)
      !aresetn |=> !sleep_indicator && !reduced_power_request)
      else $error("reset left an indicator high");
   a_we_fanout: assert property (regblk_we_out == {`CSG_NUM_BLOCKS{regblk_we}})
      else $error("shared write enable not fanned out");
   // Sampled at the falling edge so a gated clock shows its high phase
   a_gated_asleep: assert property (@(negedge aclk)
      TOP_GATING && sleep_indicator && $past(sleep_indicator) |-> !core_clk)
      else $error("core clock runs while asleep");
   a_clk_awake: assert property (@(negedge aclk)
      !sleep_indicator && !$past(sleep_indicator) |-> core_clk)
      else $error("core clock stopped while awake");
   a_wake_runs: assert property (@(negedge aclk) wake_clk)
      else $error("wake logic clock stopped");
   a_blk_only: assert property (@(negedge aclk)
      FINE_GATING |->
      (regblk_clk & ~$past({`CSG_NUM_BLOCKS{regblk_we}} & regblk_sel)) == '0)
      else $error("block clocked without access");
   c_sleep: cover property ($rose(sleep_indicator));
   c_rp: cover property ($rose(reduced_power_request));
   c_blk: cover property (@(negedge aclk) |regblk_clk);
endmodule : csg_sleep_chk

bind csg_core_sleep csg_sleep_chk #(.TOP_GATING(TOP_GATING), .FINE_GATING(FINE_GATING)) chk_i (
   .aclk(aclk), .aresetn(aresetn), .ops_pending(ops_pending), .core_nmi(core_nmi),
   .regblk_we(regblk_we), .regblk_sel(regblk_sel), .sleep_indicator(sleep_indicator),
   .reduced_power_request(reduced_power_request), .pipeline_freeze(pipeline_freeze),
   .core_clk(core_clk), .wake_clk(wake_clk), .regblk_clk(regblk_clk),
   .regblk_we_out(regblk_we_out));

// ---- dv/csg_pm_model.sv ----
`timescale 1ns/1ps
module csg_pm_model #(
   parameter int HOLD = 100
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       sleep_indicator,
   input  wire logic [1:0] wake_kind,
   output logic      [5:0] core_int,
   output logic            core_nmi,
   output logic            debug_mode_signal
);
   int hold_cnt;
   // Built with top gating, so the input clock is never stopped here
   // Reduced-power request left alone: clock and wake detection stay
   // Supply is never lowered, so a wake may follow the hold directly
   always_ff @(posedge aclk) begin
      if (!aresetn || !sleep_indicator) begin
         hold_cnt          <= 0;
         core_int          <= 6'h00;
         core_nmi          <= 1'b0;
         debug_mode_signal <= 1'b0;
      end else if (hold_cnt < HOLD) begin
         hold_cnt <= hold_cnt + 1;
      end else begin
         core_int[0]       <= (wake_kind == 2'd0);
         core_nmi          <= (wake_kind == 2'd1);
         debug_mode_signal <= (wake_kind == 2'd2);
      end
   end
endmodule : csg_pm_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`include "csg_defs.svh"
module tb;
   logic        aclk, aresetn = 1'b0, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, halt_exec, ops_pending, core_nmi, debug_mode_signal, regblk_we;
   logic        sleep_indicator, reduced_power_request, pipeline_freeze, core_clk, wake_clk;
   logic [1:0]  s_axi_bresp, s_axi_rresp, wake_kind;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, regblk_sel, regblk_clk, regblk_we_out;
   logic [5:0]  core_int;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [7:0]  bc [4] = '{default: 8'h00};
   int          err_count, checks;
   csg_core_sleep dut (.*);
   csg_pm_model pm (.*);
   for (genvar g = 0; g < 4; g++) begin : g_cnt
      always @(posedge regblk_clk[g]) bc[g] <= bc[g] + 8'h01;
   end
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      chk(s_axi_bresp, er);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      chk(s_axi_rdata & mask, exp);
      chk(s_axi_rresp, `CSG_RESP_OKAY);
   endtask : rd
   task automatic wait_sleep(input logic v);
      int n;
      n = 0;
      while (sleep_indicator !== v && n < 300) begin
         @(posedge aclk);
         n++;
      end
      chk(sleep_indicator, v);
   endtask : wait_sleep
   // Hardware halt drains with work pending; the software halt bit has none
   task automatic nap(input logic [1:0] k, input logic [31:0] ctrl, input logic wakes);
      wake_kind <= k;
      wr(`CSG_ADDR_CTRL, ctrl, `CSG_RESP_OKAY);
      if (!ctrl[`CSG_CTRL_HALT_BIT]) begin
         halt_exec <= 1'b1;
         ops_pending <= 1'b1;
         repeat (10) @(posedge aclk);
         chk(sleep_indicator, 1'b0);
         chk(pipeline_freeze, 1'b0);
         ops_pending <= 1'b0;
      end
      wait_sleep(1'b1);
      halt_exec <= 1'b0;
      if (wakes) wait_sleep(1'b0);
   endtask : nap
   task automatic blk(input logic [3:0] sel, input logic [3:0] exp);
      logic [7:0] b0 [4];
      b0 = bc;
      regblk_sel <= sel;
      regblk_we <= 1'b1;
      @(posedge aclk);
      regblk_we <= 1'b0;
      regblk_sel <= 4'h0;
      repeat (3) @(posedge aclk);
      for (int i = 0; i < 4; i++) chk(bc[i] - b0[i], exp[i]);
   endtask : blk
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   initial begin
      #400000;
      err_count++;
      end_sim();
   end
   initial begin
      // Response readies stay high, so two transfers never touch them at one edge
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= '0;
      {s_axi_bready, s_axi_rready} <= 2'b11;
      {halt_exec, ops_pending, regblk_we} <= '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, regblk_sel, wake_kind} <= '0;
      s_axi_wdata <= '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`CSG_ADDR_CTRL, '1, 32'h0);
      rd(`CSG_ADDR_BLKEN, '1, 32'hf);
      rd(`CSG_ADDR_STATUS, '1, 32'h0);
      wr(`CSG_ADDR_STATUS, 32'h1, `CSG_RESP_SLVERR);
      wr(`CSG_ADDR_WAKECNT, 32'h1, `CSG_RESP_SLVERR);
      $display("test registers done");
      wr(`CSG_ADDR_CTRL, 32'h1, `CSG_RESP_OKAY);
      repeat (20) @(posedge aclk);
      chk(reduced_power_request, 1'b1);
      chk(sleep_indicator, 1'b0);
      rd(`CSG_ADDR_STATUS, 32'h40, 32'h40);
      wr(`CSG_ADDR_CTRL, 32'h0, `CSG_RESP_OKAY);
      @(posedge aclk);
      chk(reduced_power_request, 1'b0);
      $display("test reduced power done");
      blk(4'h2, 4'h2);
      blk(4'h8, 4'h8);
      wr(`CSG_ADDR_BLKEN, 32'hd, `CSG_RESP_OKAY);
      blk(4'h2, 4'h0);
      blk(4'h1, 4'h1);
      $display("test fine gating done");
      nap(2'd0, 32'h100, 1'b1);
      nap(2'd1, 32'h0, 1'b1);
      nap(2'd2, 32'h2, 1'b1);
      rd(`CSG_ADDR_WAKECNT, '1, 32'h3);
      rd(`CSG_ADDR_BLKEN, '1, 32'hd);
      rd(`CSG_ADDR_STATUS, 32'h80, 32'h80);
      $display("test wake events done");
      nap(2'd0, 32'h0, 1'b0);
      repeat (150) @(posedge aclk);
      chk(sleep_indicator, 1'b1);
      rd(`CSG_ADDR_STATUS, 32'hff, 32'h33);
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(sleep_indicator, 1'b0);
      rd(`CSG_ADDR_WAKECNT, '1, 32'h0);
      rd(`CSG_ADDR_BLKEN, '1, 32'hf);
      $display("test reset exit done");
      end_sim();
   end
endmodule : tb
